// ---- pkg/ebt_pkg.sv ----
package ebt_pkg;

  // ---------------------------------------------------------------
  // register map (word index on the plain register port)
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 3;
  localparam logic [2:0]  OFF_CONTROL     = 3'h0;
  localparam logic [2:0]  OFF_COUNTER     = 3'h1;
  localparam logic [2:0]  OFF_SCALER      = 3'h2;
  localparam logic [2:0]  OFF_BOUND       = 3'h3;
  localparam logic [2:0]  OFF_INT_STATUS  = 3'h4;
  localparam logic [2:0]  OFF_INT_ENABLE  = 3'h5;
  localparam logic [2:0]  OFF_INT_CLEAR   = 3'h6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_CONTROL     = 8'h00;
  localparam logic [7:0]  RST_COUNTER     = 8'h00;
  localparam logic [7:0]  RST_SCALER      = 8'h00;
  localparam logic [7:0]  RST_BOUND       = 8'h00;
  localparam logic [1:0]  RST_INT         = 2'h0;

  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  localparam int          CTL_SRC_LSB     = 4;
  localparam int          CTL_ROUTE_LSB   = 2;
  localparam int          CTL_PWM_BIT     = 1;
  localparam int          SCL_SIX_BIT     = 7;
  localparam int          SCL_PRE_LSB     = 5;
  localparam int          SCL_DIV_LSB     = 0;
  localparam int          INT_PERIOD_BIT  = 0;
  localparam int          INT_WRAP_BIT    = 1;

  // clock source codes of control[7:4]
  localparam logic [3:0]  SRC_STOP        = 4'h0;
  localparam logic [3:0]  SRC_SYSCLK      = 4'h1;
  localparam logic [3:0]  SRC_FAST_RC     = 4'h2;
  localparam logic [3:0]  SRC_SLOW_RC     = 4'h3;
  localparam logic [3:0]  SRC_PIN0        = 4'h4;
  localparam logic [3:0]  SRC_PIN1        = 4'h5;
  localparam logic [3:0]  SRC_PIN2        = 4'h6;
  localparam logic [3:0]  SRC_COMPARATOR  = 4'h7;

  // output routing codes of control[3:2]
  localparam logic [1:0]  ROUTE_NONE      = 2'h0;

  // counter tops for the two pwm resolutions
  localparam logic [7:0]  TOP_PWM8        = 8'hff;
  localparam logic [7:0]  TOP_PWM6        = 8'h3f;

  typedef struct packed {
    logic [3:0] src;
    logic [1:0] route;
    logic       pwm;
    logic       rsvd;
  } ebt_ctrl_t;

  typedef struct packed {
    logic       six_bit;
    logic [1:0] pre;
    logic [4:0] div;
  } ebt_scaler_t;

endpackage : ebt_pkg

// ---- rtl/ebt_clk_scaler.sv ----
module ebt_clk_scaler #(
  parameter int PRE_W = 6,
  parameter int DIV_W = 5
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // source ticks and settings
  input  wire logic             i_tick,
  input  wire logic [1:0]       i_pre_sel,
  input  wire logic [DIV_W-1:0] i_div,
  // scaled timer tick
  output logic                  o_tick
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (PRE_W < 6 || DIV_W < 1) begin : g_chk
    $error("ebt_clk_scaler: prescaler needs 6 bits and scaler at least 1");
  end

  logic [PRE_W-1:0] pre_cnt_q;
  logic [PRE_W-1:0] pre_top;
  logic [DIV_W-1:0] div_cnt_q;
  logic             pre_tick;

  // prescale terminal count: divide by 1, 4, 16 or 64
  always_comb begin
    case (i_pre_sel)
      2'h0:    pre_top = PRE_W'(0);
      2'h1:    pre_top = PRE_W'(3);
      2'h2:    pre_top = PRE_W'(15);
      default: pre_top = PRE_W'(63);
    endcase
  end

  assign pre_tick = i_tick && (pre_cnt_q >= pre_top); // [R4]
  assign o_tick   = pre_tick && (div_cnt_q >= i_div); // [R5]

  // prescaler count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pre_cnt_q <= '0;
    end else if (pre_tick) begin
      pre_cnt_q <= '0;
    end else if (i_tick) begin
      pre_cnt_q <= pre_cnt_q + PRE_W'(1); // [R4]
    end
  end

  // scaler count, divide by field plus one
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_cnt_q <= '0;
    end else if (o_tick) begin
      div_cnt_q <= '0;
    end else if (pre_tick) begin
      div_cnt_q <= div_cnt_q + DIV_W'(1); // [R5]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_pre_by_one;
    @(posedge i_clk) disable iff (i_rst)
      (i_pre_sel == 2'h0 && i_tick) |-> pre_tick;
  endproperty
  a_pre_by_one: assert property (p_pre_by_one) // [R4]
    else $error("prescale by one did not pass the source tick");

  property p_scale_gap;
    @(posedge i_clk) disable iff (i_rst)
      (o_tick && i_div == 5'h01 && $stable(i_pre_sel) && i_pre_sel == 2'h0)
        |=> !o_tick;
  endproperty
  a_scale_gap: assert property (p_scale_gap) // [R5]
    else $error("divide by two gave back to back scaled ticks");

endmodule : ebt_clk_scaler

// ---- rtl/ebt_timer.sv ----
// Operation
// [R1] control high nibble selects the clock source
// [R2] control bits 3..2 route output to pin
// [R3] routed output overrides the pin direction setting
// [R4] prescaler divides by 1, 4, 16, 64
// [R5] scaler divides by field value plus one
// [R6] counter counts up, software reads and writes
// [R7] counter clears to zero at upper bound
// [R8] control bit 1 selects pwm, else period
// [R9] period mode gives waveform or interrupt event
// [R10] period mode square wave, fifty percent duty
// [R11] pwm eight bit when scaler bit 7 clear
// [R12] comparator high stops pwm when option built
// [R13] period output toggles at each bound clear
// [R14] eight bit pwm period 256, duty (K+1)/256
// [R15] bound 255 keeps eight bit pwm high
// [R16] six bit pwm: period 64, duty (K+1)/64
//
// The strobed register port and the placing of the registers were left to the implementer.
module ebt_timer #(
  parameter bit GATE_OPTION = 1'b0,
  parameter int PIN_COUNT   = 3
) (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // register port
  input  wire logic [ebt_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [7:0]                    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [7:0]                    o_rdata,
  // clock sources, sampled as levels
  input  wire logic                          i_fast_rc_clk,
  input  wire logic                          i_slow_rc_clk,
  input  wire logic [PIN_COUNT-1:0]          i_src_pin,
  input  wire logic                          i_comparator,
  // port pins: normal port drive and the forced result
  input  wire logic [PIN_COUNT-1:0]          i_port_out,
  input  wire logic [PIN_COUNT-1:0]          i_port_oe_n,
  output logic      [PIN_COUNT-1:0]          o_pin_out,
  output logic      [PIN_COUNT-1:0]          o_pin_oe_n,
  // interrupt
  output logic                               o_irq
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (PIN_COUNT != 3) begin : g_chk
    $error("ebt_timer: routing field serves exactly three pins");
  end

  ebt_pkg::ebt_ctrl_t   ctrl_q;
  ebt_pkg::ebt_scaler_t scal_q;
  logic [7:0]           cnt_q;
  logic [7:0]           bound_q;
  logic [1:0]           stat_q;
  logic [1:0]           stat_d;
  logic [1:0]           ien_q;
  logic [7:0]           rdata_q;
  logic                 irq_q;
  logic                 wave_q;
  logic [PIN_COUNT-1:0] pin_out_q;
  logic [PIN_COUNT-1:0] pin_oe_n_q;
  logic                 fast_prev_q;
  logic                 slow_prev_q;
  logic [PIN_COUNT-1:0] pin_prev_q;
  logic                 cmp_prev_q;
  logic                 src_tick;
  logic                 tm_tick;
  logic                 wr_ctrl;
  logic                 wr_cnt;
  logic                 wr_scal;
  logic                 wr_bound;
  logic                 wr_ien;
  logic                 wr_clr;
  logic [7:0]           pwm_top;
  logic [7:0]           top;
  logic                 at_top;
  logic                 pwm_level;
  logic                 gate;
  logic [1:0]           ev;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  always_comb begin
    wr_ctrl  = 1'b0;
    wr_cnt   = 1'b0;
    wr_scal  = 1'b0;
    wr_bound = 1'b0;
    wr_ien   = 1'b0;
    wr_clr   = 1'b0;
    if (i_wr && i_addr == ebt_pkg::OFF_CONTROL) begin
      wr_ctrl = 1'b1;
    end else if (i_wr && i_addr == ebt_pkg::OFF_COUNTER) begin
      wr_cnt = 1'b1;
    end else if (i_wr && i_addr == ebt_pkg::OFF_SCALER) begin
      wr_scal = 1'b1;
    end else if (i_wr && i_addr == ebt_pkg::OFF_BOUND) begin
      wr_bound = 1'b1;
    end else if (i_wr && i_addr == ebt_pkg::OFF_INT_ENABLE) begin
      wr_ien = 1'b1;
    end else if (i_wr && i_addr == ebt_pkg::OFF_INT_CLEAR) begin
      wr_clr = 1'b1;
    end
  end

  // control, scaler and bound registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q  <= ebt_pkg::RST_CONTROL;
      scal_q  <= ebt_pkg::RST_SCALER;
      bound_q <= ebt_pkg::RST_BOUND;
      ien_q   <= ebt_pkg::RST_INT;
    end else begin
      if (wr_ctrl) begin
        ctrl_q      <= i_wdata;
        ctrl_q.rsvd <= 1'b0; // reserved bit reads zero
      end
      if (wr_scal) begin
        scal_q <= i_wdata;
      end
      if (wr_bound) begin
        bound_q <= i_wdata;
      end
      if (wr_ien) begin
        ien_q <= i_wdata[1:0];
      end
    end
  end

  // read data stands for one cycle after the read strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else if (!i_rd) begin
      rdata_q <= 8'h00;
    end else if (i_addr == ebt_pkg::OFF_CONTROL) begin
      rdata_q <= ctrl_q;
    end else if (i_addr == ebt_pkg::OFF_COUNTER) begin
      rdata_q <= cnt_q; // [R6]
    end else if (i_addr == ebt_pkg::OFF_SCALER) begin
      rdata_q <= scal_q;
    end else if (i_addr == ebt_pkg::OFF_BOUND) begin
      rdata_q <= bound_q;
    end else if (i_addr == ebt_pkg::OFF_INT_STATUS) begin
      rdata_q <= {6'h00, stat_q};
    end else if (i_addr == ebt_pkg::OFF_INT_ENABLE) begin
      rdata_q <= {6'h00, ien_q};
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // clock source selection
  // ---------------------------------------------------------------
  // previous samples for rising edge detection
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fast_prev_q <= 1'b0;
      slow_prev_q <= 1'b0;
      pin_prev_q  <= '0;
      cmp_prev_q  <= 1'b0;
    end else begin
      fast_prev_q <= i_fast_rc_clk;
      slow_prev_q <= i_slow_rc_clk;
      pin_prev_q  <= i_src_pin;
      cmp_prev_q  <= i_comparator;
    end
  end

  // one tick per rising edge of the chosen source
  always_comb begin
    case (ctrl_q.src) // [R1]
      ebt_pkg::SRC_SYSCLK:     src_tick = 1'b1;
      ebt_pkg::SRC_FAST_RC:    src_tick = i_fast_rc_clk && !fast_prev_q;
      ebt_pkg::SRC_SLOW_RC:    src_tick = i_slow_rc_clk && !slow_prev_q;
      ebt_pkg::SRC_PIN0:       src_tick = i_src_pin[0] && !pin_prev_q[0];
      ebt_pkg::SRC_PIN1:       src_tick = i_src_pin[1] && !pin_prev_q[1];
      ebt_pkg::SRC_PIN2:       src_tick = i_src_pin[2] && !pin_prev_q[2];
      ebt_pkg::SRC_COMPARATOR: src_tick = i_comparator && !cmp_prev_q;
      default:                 src_tick = 1'b0;
    endcase
  end

  ebt_clk_scaler #(
    .PRE_W (6),
    .DIV_W (5)
  ) u_scaler (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_tick    (src_tick),
    .i_pre_sel (scal_q.pre),
    .i_div     (scal_q.div),
    .o_tick    (tm_tick)
  );

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  assign pwm_top   = scal_q.six_bit ? ebt_pkg::TOP_PWM6 : ebt_pkg::TOP_PWM8; // [R11] [R16]
  assign top       = ctrl_q.pwm ? pwm_top : bound_q; // [R8] [R14]
  assign at_top    = ((cnt_q & top) == top) && (ctrl_q.pwm || cnt_q == bound_q);
  assign pwm_level = scal_q.six_bit ? (cnt_q[5:0] <= bound_q[5:0])  // [R16]
                                    : (cnt_q <= bound_q);           // [R14] [R15]
  assign gate      = GATE_OPTION && i_comparator; // [R12]

  // up count, clear at top; a software write wins over a tick
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= ebt_pkg::RST_COUNTER;
    end else if (wr_cnt) begin
      cnt_q <= i_wdata; // [R6]
    end else if (tm_tick && at_top) begin
      cnt_q <= 8'h00; // [R7]
    end else if (tm_tick) begin
      cnt_q <= cnt_q + 8'h01; // [R6]
    end
  end

  // waveform: toggle in period mode, compare in pwm mode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wave_q <= 1'b0;
    end else if (!ctrl_q.pwm) begin
      if (tm_tick && at_top && !wr_cnt) begin
        wave_q <= !wave_q; // [R10] [R13]
      end
    end else begin
      wave_q <= pwm_level && !gate; // [R12] [R15]
    end
  end

  // forced drive of the routed pin, port setting elsewhere
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_out_q  <= '0;
      pin_oe_n_q <= '1;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (ctrl_q.route == 2'(i + 1)) begin
          pin_out_q[i]  <= wave_q; // [R2]
          pin_oe_n_q[i] <= 1'b0;   // [R3]
        end else begin
          pin_out_q[i]  <= i_port_out[i];
          pin_oe_n_q[i] <= i_port_oe_n[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  assign ev[ebt_pkg::INT_PERIOD_BIT] = tm_tick && at_top && !wr_cnt && !ctrl_q.pwm; // [R9]
  assign ev[ebt_pkg::INT_WRAP_BIT]   = tm_tick && at_top && !wr_cnt && ctrl_q.pwm;
  assign stat_d = (stat_q & ~({2{wr_clr}} & i_wdata[1:0])) | ev; // set wins over clear

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_q <= ebt_pkg::RST_INT;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= |(stat_q & ien_q);
    end
  end

  assign o_rdata    = rdata_q;
  assign o_pin_out  = pin_out_q;
  assign o_pin_oe_n = pin_oe_n_q;
  assign o_irq      = irq_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_src_stop;
    @(posedge i_clk) disable iff (i_rst)
      (ctrl_q.src == ebt_pkg::SRC_STOP) |-> !src_tick && !tm_tick;
  endproperty
  a_src_stop: assert property (p_src_stop) // [R1]
    else $error("stopped source still produced a tick");

  property p_route_force;
    @(posedge i_clk) disable iff (i_rst)
      (ctrl_q.route == 2'h2 && $stable(ctrl_q.route)) |=> !o_pin_oe_n[1];
  endproperty
  a_route_force: assert property (p_route_force) // [R2] [R3]
    else $error("routed pin not forced to drive");

  property p_route_value;
    @(posedge i_clk) disable iff (i_rst)
      (ctrl_q.route == 2'h1) |=> (o_pin_out[0] == $past(wave_q));
  endproperty
  a_route_value: assert property (p_route_value) // [R2]
    else $error("routed pin does not carry the waveform");

  property p_count_up;
    @(posedge i_clk) disable iff (i_rst)
      (tm_tick && !at_top && !wr_cnt) |=> (cnt_q == $past(cnt_q) + 8'h01);
  endproperty
  a_count_up: assert property (p_count_up) // [R6]
    else $error("counter did not step up by one");

  property p_bound_clear;
    @(posedge i_clk) disable iff (i_rst)
      (!ctrl_q.pwm && tm_tick && cnt_q == bound_q && !wr_cnt)
        |=> (cnt_q == 8'h00) && (wave_q != $past(wave_q)) && stat_q[0];
  endproperty
  a_bound_clear: assert property (p_bound_clear) // [R7] [R9] [R13]
    else $error("bound reach did not clear, toggle and flag");

  property p_sw_write;
    @(posedge i_clk) disable iff (i_rst)
      wr_cnt |=> (cnt_q == $past(i_wdata));
  endproperty
  a_sw_write: assert property (p_sw_write) // [R6]
    else $error("counter write lost");

  property p_pwm_wrap8;
    @(posedge i_clk) disable iff (i_rst)
      (ctrl_q.pwm && !scal_q.six_bit && tm_tick && cnt_q == 8'hff && !wr_cnt)
        |=> (cnt_q == 8'h00);
  endproperty
  a_pwm_wrap8: assert property (p_pwm_wrap8) // [R11] [R14]
    else $error("eight bit pwm did not wrap at 255");

  property p_pwm_full;
    @(posedge i_clk) disable iff (i_rst)
      (ctrl_q.pwm && !scal_q.six_bit && bound_q == 8'hff && !gate) |=> wave_q;
  endproperty
  a_pwm_full: assert property (p_pwm_full) // [R15]
    else $error("bound 255 did not hold the output high");

  property p_pwm6;
    @(posedge i_clk) disable iff (i_rst)
      (ctrl_q.pwm && scal_q.six_bit && tm_tick && cnt_q[5:0] == 6'h3f && !wr_cnt)
        |=> (cnt_q == 8'h00);
  endproperty
  a_pwm6: assert property (p_pwm6) // [R16]
    else $error("six bit pwm did not wrap at 63");

  property p_gate;
    @(posedge i_clk) disable iff (i_rst)
      (ctrl_q.pwm && gate) |=> !wave_q;
  endproperty
  a_gate: assert property (p_gate) // [R12]
    else $error("pwm output not stopped by comparator");

  property p_irq;
    @(posedge i_clk) disable iff (i_rst)
      (|(stat_q & ien_q)) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) // [R9]
    else $error("enabled status did not raise the interrupt");

endmodule : ebt_timer

// ---- verif/ebt_pin_load.sv ----
module ebt_pin_load (
  // clock and measure control
  input  wire logic        i_clk,
  input  wire logic        i_clr,
  input  wire logic [1:0]  i_sel,
  // pins from the timer
  input  wire logic [2:0]  i_pin_out,
  input  wire logic [2:0]  i_pin_oe_n,
  // measured counts
  output logic      [15:0] o_high,
  output logic      [15:0] o_rise
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] level;
  logic       prev_q;

  // a released pin is held low by the pull-down, never the last value
  assign level = ~i_pin_oe_n & i_pin_out;

  // count high cycles and rising edges on the watched pin
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      o_high <= 16'h0;
      o_rise <= 16'h0;
    end else begin
      o_high <= o_high + 16'(level[i_sel]);
      o_rise <= o_rise + 16'(level[i_sel] & ~prev_q);
    end
    prev_q <= level[i_sel];
  end
endmodule : ebt_pin_load

// ---- verif/ebt_timer_bench.sv ----
module ebt_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0]  ctl;
    logic [7:0]  scl;
    logic [7:0]  bnd;
    int          w;
    logic [15:0] h;
    logic [15:0] r;
  } ebt_row_t;

  logic        i_clk, i_rst, i_wr, i_rd, o_irq;
  logic        src_tog, cmp_lvl, cmp_tog, mclr;
  logic [1:0]  msel;
  logic [2:0]  i_addr, o_pin_out, o_pin_oe_n;
  logic [7:0]  i_wdata, o_rdata, rv;
  logic [15:0] hi_cnt, rise_cnt;
  int          error_cnt, checks_done;

  // mode cases: control, scaler, bound, window, high cycles, rising edges
  ebt_row_t rows [10] = '{
    '{8'h18, 8'h00, 8'h01, 64, 16'h20, 16'h10},
    '{8'h18, 8'h21, 8'h03, 256, 16'h80, 16'h4},
    '{8'h1a, 8'h00, 8'h09, 256, 16'ha, 16'h1},
    '{8'h1a, 8'h00, 8'hff, 256, 16'h100, 16'h0},
    '{8'h1a, 8'h80, 8'h1f, 64, 16'h20, 16'h1},
    '{8'h1a, 8'h80, 8'h00, 64, 16'h1, 16'h1},
    '{8'h18, 8'h01, 8'h01, 64, 16'h20, 16'h8},
    '{8'h18, 8'h40, 8'h00, 256, 16'h80, 16'h8},
    '{8'h18, 8'h60, 8'h00, 256, 16'h80, 16'h2},
    '{8'h18, 8'h1f, 8'h00, 256, 16'h80, 16'h4}
  };

  // ---------------------------------------------------------------
  // clock, design and far-side load
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // toggling source for rc, pin and comparator clock inputs
  always @(posedge i_clk) src_tog <= ~src_tog;

  ebt_timer #(.GATE_OPTION(1'b1), .PIN_COUNT(3)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_fast_rc_clk(src_tog), .i_slow_rc_clk(src_tog),
    .i_src_pin({3{src_tog}}), .i_comparator(cmp_tog ? src_tog : cmp_lvl),
    .i_port_out(3'h5), .i_port_oe_n(3'h7), .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n), .o_irq(o_irq)
  );

  ebt_pin_load load (
    .i_clk(i_clk), .i_clr(mclr), .i_sel(msel), .i_pin_out(o_pin_out),
    .i_pin_oe_n(o_pin_oe_n), .o_high(hi_cnt), .o_rise(rise_cnt)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(negedge i_clk);
    rv = o_rdata;
  endtask : rd

  // stop, program a mode, let it settle, then measure the pin
  task automatic run(input logic [7:0] c, input logic [7:0] s, input logic [7:0] b,
                     input int w, input logic [15:0] h, input logic [15:0] r);
    wr(ebt_pkg::OFF_CONTROL, 8'h00);
    wr(ebt_pkg::OFF_BOUND, b);
    wr(ebt_pkg::OFF_SCALER, s);
    wr(ebt_pkg::OFF_COUNTER, 8'h00);
    wr(ebt_pkg::OFF_CONTROL, c);
    repeat (300) @(posedge i_clk);
    mclr <= 1'b1;
    @(posedge i_clk);
    mclr <= 1'b0;
    repeat (w) @(posedge i_clk);
    #1;
    chk("high cycles", hi_cnt, h);
    chk("rising edges", rise_cnt, r);
    chk("pin enable", {15'h0, ~o_pin_oe_n[msel]}, 16'h1);
  endtask : run

  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge i_clk);
    error_cnt++;
    close_out();
  end

  initial begin
    i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 3'h0; i_wdata = 8'h00;
    src_tog = 1'b0; cmp_lvl = 1'b0; cmp_tog = 1'b0; mclr = 1'b0; msel = 2'h1;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset values, unmapped index included
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      chk("reset read", 16'(rv), 16'h0);
    end
    chk("pins after reset", 16'(o_pin_out), 16'h5);
    // mode cases in one loop
    foreach (rows[i]) begin
      run(rows[i].ctl, rows[i].scl, rows[i].bnd, rows[i].w, rows[i].h, rows[i].r);
    end
    rd(ebt_pkg::OFF_INT_STATUS);
    chk("status events", 16'(rv), 16'h3);
    // each rc, pin and comparator clock source, period mode at bound zero
    cmp_tog <= 1'b1;
    for (int s = 2; s < 8; s++) begin
      run({4'(s), 4'h8}, 8'h00, 8'h00, 64, 16'h20, 16'h10);
    end
    cmp_tog <= 1'b0;
    // route codes 1 to 3 each land on their own pin
    for (int p = 1; p < 4; p++) begin
      msel <= 2'(p - 1);
      run({4'h1, 2'(p), 2'h0}, 8'h00, 8'h01, 64, 16'h20, 16'h10);
    end
    // comparator high stops pwm, low lets it run again
    cmp_lvl <= 1'b1;
    msel    <= 2'h1; // pwm goes to pin1 again
    run(8'h1a, 8'h00, 8'h7f, 256, 16'h0, 16'h0);
    cmp_lvl <= 1'b0;
    run(8'h1a, 8'h00, 8'h7f, 256, 16'h80, 16'h1);
    // register access kinds
    wr(ebt_pkg::OFF_CONTROL, 8'hf7);
    wr(ebt_pkg::OFF_INT_CLEAR, 8'hff);
    rd(ebt_pkg::OFF_CONTROL);
    chk("control", 16'(rv), 16'hf6);
    wr(ebt_pkg::OFF_COUNTER, 8'h5a);
    repeat (5) @(posedge i_clk);
    rd(ebt_pkg::OFF_COUNTER);
    chk("counter", 16'(rv), 16'h5a);
    wr(ebt_pkg::OFF_SCALER, 8'ha5);
    rd(ebt_pkg::OFF_SCALER);
    chk("scaler", 16'(rv), 16'ha5);
    wr(3'h7, 8'hff);
    wr(ebt_pkg::OFF_INT_STATUS, 8'hff);
    rd(ebt_pkg::OFF_INT_STATUS);
    chk("status read only", 16'(rv), 16'h0);
    rd(3'h7);
    chk("unmapped", 16'(rv), 16'h0);
    // interrupt: masked, enabled, cleared
    run(8'h18, 8'h00, 8'h01, 64, 16'h20, 16'h10);
    chk("irq masked", 16'(o_irq), 16'h0);
    wr(ebt_pkg::OFF_INT_ENABLE, 8'h01);
    repeat (3) @(negedge i_clk);
    chk("irq raised", 16'(o_irq), 16'h1);
    wr(ebt_pkg::OFF_CONTROL, 8'h00);
    wr(ebt_pkg::OFF_INT_CLEAR, 8'h03);
    repeat (3) @(negedge i_clk);
    chk("irq cleared", 16'(o_irq), 16'h0);
    rd(ebt_pkg::OFF_INT_STATUS);
    chk("status cleared", 16'(rv), 16'h0);
    // no route: pins show the port again
    chk("pin out unrouted", 16'(o_pin_out), 16'h5);
    chk("pin enable unrouted", 16'(o_pin_oe_n), 16'h7);
    // mid-run reset returns pin enables, interrupt and control register to reset values
    wr(ebt_pkg::OFF_CONTROL, 8'h18);
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk("pin enable after reset", 16'(o_pin_oe_n), 16'h7);
    chk("irq after reset", 16'(o_irq), 16'h0);
    rd(ebt_pkg::OFF_CONTROL);
    chk("control after reset", 16'(rv), 16'h0);
    close_out();
  end
endmodule : ebt_timer_bench
